// ### pmic_irq_regs.vh
// Register map, field layout and timing constants of the interrupt block
`ifndef PMIC_IRQ_REGS_VH
`define PMIC_IRQ_REGS_VH

// Register byte offsets
`define ADDR_STATUS     12'h000
`define ADDR_MASK       12'h004
`define ADDR_SENSE      12'h008
`define ADDR_BTN_CFG    12'h00C

// Widths
`define N_FLAGS         21
`define N_CHAN          22
`define DB_W            24
`define BTN_CFG_W       6

// Reset values
`define MASK_RESET      21'h0FFFFF
`define BTN_CFG_RESET   6'h00
`define STATUS_RESET    21'h000000

// Flag bit positions and the charger-active channel index
`define F_CONV_DONE     0
`define F_CONV2_DONE    1
`define F_CHG_REVERSE   2
`define F_CHG_SHORT     3
`define F_CHG_FAULT     4
`define F_CHG_CUR_LOW   5
`define F_CHG_DETECT    6
`define F_A_SESSION     7
`define F_B_SESSION     8
`define F_ID_FLOAT      9
`define F_ID_GROUND     10
`define F_ID_FACTORY    11
`define F_BUTTON1       12
`define F_BUTTON2       13
`define F_BUTTON3       14
`define F_THERM_HIGH    15
`define F_THERM_LOW     16
`define F_CLK_SRC       17
`define F_BATT_LOW_DET  18
`define F_BATT_LOW_WARN 19
`define F_LP_BOOT       20
`define C_CHG_ACTIVE    21

// Trigger kinds
`define TRIG_RISE       2'h1
`define TRIG_FALL       2'h2
`define TRIG_DUAL       2'h3

// Timing
`define CLK_HZ          20000000
`define CYC_PER_MS      24'h004E20
`define CYC_PER_US      24'h000014
`define DB_NONE_CYC     24'h000001
`define DB_CHG_REV_MS   24'h000001
`define DB_CHG_FAULT_MS 24'h00000A
`define DB_CHG_CUR_MS   24'h000001
`define DB_CHG_DET_MS   24'h000020
`define DB_CHG_ACT_MS   24'h000064
`define DB_SESS_RISE_MS 24'h000018
`define DB_SESS_FALL_MS 24'h00000C
`define DB_ID_US        24'h00005A
`define DB_BUTTON_MS    24'h00001E
`define DB_THERM_MS     24'h00001E
`define DB_BATT_WARN_US 24'h00001E
`define DB_LP_BOOT_MS   24'h000001

`endif

// ### stable_filter.v
// Debounce filter: output follows input after it stays stable long enough
`timescale 1ns/100ps
`include "pmic_irq_regs.vh"
module stable_filter (
  input  wire                clk_i,
  input  wire                sys_rst_i,
  input  wire                raw_i,
  input  wire [`DB_W-1:0]    rise_len_i,
  input  wire [`DB_W-1:0]    fall_len_i,
  output reg                 level_o
);
  reg  [`DB_W-1:0] count;
  wire [`DB_W-1:0] count_inc;
  wire [`DB_W-1:0] need;

  assign count_inc = count + `DB_W'h1;
  assign need      = raw_i ? rise_len_i : fall_len_i;

  // Restart count on any bounce back to the settled level
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      count   <= {`DB_W{1'b0}};
      level_o <= 1'b0;
    end else if (raw_i == level_o) begin
      count <= {`DB_W{1'b0}};
    end else if (count_inc >= need) begin
      count   <= {`DB_W{1'b0}};
      level_o <= raw_i;
    end else begin
      count <= count_inc;
    end
  end
endmodule // stable_filter

// ### edge_event.v
// Edge qualifier: one-cycle pulse on the selected edge of a level
`timescale 1ns/100ps
`include "pmic_irq_regs.vh"
module edge_event (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       level_i,
  input  wire [1:0] trig_i,
  output wire       pulse_o
);
  reg prev;
  reg primed;

  // No edge is seen in the first cycle after reset
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev   <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev   <= level_i;
      primed <= 1'b1;
    end
  end

  assign pulse_o = primed & (((trig_i == `TRIG_RISE) & level_i & ~prev) |
                             ((trig_i == `TRIG_FALL) & ~level_i & prev) |
                             ((trig_i == `TRIG_DUAL) & (level_i ^ prev)));
endmodule // edge_event

// ### pmic_interrupt_control.v
// Interrupt collection block: debounce, flags, masks, sense and APB slave
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "pmic_irq_regs.vh"
module pmic_interrupt_control #(
  parameter [`DB_W-1:0] CHG_REV_CYC   = `DB_CHG_REV_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] CHG_FAULT_CYC = `DB_CHG_FAULT_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] CHG_CUR_CYC   = `DB_CHG_CUR_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] CHG_DET_CYC   = `DB_CHG_DET_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] CHG_ACT_CYC   = `DB_CHG_ACT_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] SESS_RISE_CYC = `DB_SESS_RISE_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] SESS_FALL_CYC = `DB_SESS_FALL_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] BUTTON_CYC    = `DB_BUTTON_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] THERM_CYC     = `DB_THERM_MS * `CYC_PER_MS,
  parameter [`DB_W-1:0] LP_BOOT_CYC   = `DB_LP_BOOT_MS * `CYC_PER_MS
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        conv_done_i,
  input  wire        conv2_done_i,
  input  wire        chg_reverse_i,
  input  wire        chg_short_i,
  input  wire [1:0]  chg_fault_sense_i,
  input  wire        chg_current_sense_i,
  input  wire        charger_detect_sense_i,
  input  wire        charger_active_sense_i,
  input  wire        a_session_sense_i,
  input  wire        b_session_sense_i,
  input  wire        id_float_sense_i,
  input  wire        id_ground_sense_i,
  input  wire        id_factory_sense_i,
  input  wire [2:0]  button_i,
  input  wire        thermal_high_sense_i,
  input  wire        thermal_low_sense_i,
  input  wire        clk_src_sense_i,
  input  wire        batt_low_detect_sense_i,
  input  wire        batt_low_warn_sense_i,
  input  wire        lowpower_boot_sense_i,
  input  wire [1:0]  mode_strap_sense_i,
  input  wire [3:0]  seq_strap_sense_i,
  output reg         irq_o
);
  localparam [`DB_W-1:0] ID_CYC   = `DB_ID_US * `CYC_PER_US;
  localparam [`DB_W-1:0] WARN_CYC = `DB_BATT_WARN_US * `CYC_PER_US;

  reg  [`N_FLAGS-1:0]   status;
  reg  [`N_FLAGS-1:0]   mask;
  reg  [`BTN_CFG_W-1:0] button_debounce_ext;
  reg  [24:0]           sense;
  reg  [`N_FLAGS-1:0]   next_status;
  reg  [`N_FLAGS-1:0]   events;
  reg  [`N_FLAGS-1:0]   clear_bits;
  reg  [`N_FLAGS-1:0]   next_mask;
  reg  [31:0]           next_rdata;
  reg                   next_err;
  wire [`N_CHAN-1:0]    raw;
  wire [`N_CHAN-1:0]    settled;
  wire [`N_CHAN-1:0]    pulses;
  wire                  bus_setup;
  wire                  bus_commit;
  wire                  wr_status;
  wire                  wr_mask;
  wire                  wr_btn;
  reg  [`BTN_CFG_W-1:0] next_btn_cfg;
  reg                   next_irq;

  // Rising debounce length per channel
  function [`DB_W-1:0] rise_len_of;
    input integer idx;
    begin
      case (idx)
        `F_CHG_REVERSE, `F_CHG_SHORT: rise_len_of = CHG_REV_CYC;
        `F_CHG_FAULT:                 rise_len_of = CHG_FAULT_CYC;
        `F_CHG_CUR_LOW:               rise_len_of = CHG_CUR_CYC;
        `F_CHG_DETECT:                rise_len_of = CHG_DET_CYC;
        `C_CHG_ACTIVE:                rise_len_of = CHG_ACT_CYC;
        `F_A_SESSION, `F_B_SESSION:   rise_len_of = SESS_RISE_CYC;
        `F_ID_FLOAT, `F_ID_GROUND,
        `F_ID_FACTORY:                rise_len_of = ID_CYC;
        `F_BUTTON1, `F_BUTTON2,
        `F_BUTTON3:                   rise_len_of = BUTTON_CYC;
        `F_THERM_HIGH, `F_THERM_LOW:  rise_len_of = THERM_CYC;
        `F_BATT_LOW_WARN:             rise_len_of = WARN_CYC;
        `F_LP_BOOT:                   rise_len_of = LP_BOOT_CYC;
        default:                      rise_len_of = `DB_NONE_CYC;
      endcase
    end
  endfunction

  // Button falling debounce scaled by its two-bit extension
  function [`DB_W-1:0] button_fall;
    input [1:0] ext;
    begin
      case (ext)
        2'h0:    button_fall = BUTTON_CYC;
        2'h1:    button_fall = BUTTON_CYC + BUTTON_CYC;
        2'h2:    button_fall = BUTTON_CYC + BUTTON_CYC + BUTTON_CYC;
        default: button_fall = BUTTON_CYC + BUTTON_CYC + BUTTON_CYC + BUTTON_CYC;
      endcase
    end
  endfunction

  // Falling debounce length per channel
  function [`DB_W-1:0] fall_len_of;
    input integer                idx;
    input [`BTN_CFG_W-1:0] ext;
    begin
      case (idx)
        `F_A_SESSION, `F_B_SESSION: fall_len_of = SESS_FALL_CYC;
        `F_BUTTON1:                 fall_len_of = button_fall(ext[1:0]);
        `F_BUTTON2:                 fall_len_of = button_fall(ext[3:2]);
        `F_BUTTON3:                 fall_len_of = button_fall(ext[5:4]);
        default:                    fall_len_of = rise_len_of(idx);
      endcase
    end
  endfunction

  // Trigger kind per channel
  function [1:0] trig_of;
    input integer idx;
    begin
      case (idx)
        `F_CONV_DONE, `F_CONV2_DONE, `F_CHG_REVERSE, `F_CHG_SHORT,
        `F_CHG_FAULT, `F_BATT_LOW_DET: trig_of = `TRIG_RISE;
        `F_CHG_CUR_LOW:                trig_of = `TRIG_FALL;
        default:                       trig_of = `TRIG_DUAL;
      endcase
    end
  endfunction

  // Committed write to one register offset
  function write_hit;
    input        commit;
    input [11:0] addr;
    input [11:0] target;
    begin
      write_hit = commit & (addr == target);
    end
  endfunction

  // Raw source levels per channel
  assign raw[`F_CONV_DONE]     = conv_done_i;
  assign raw[`F_CONV2_DONE]    = conv2_done_i;
  assign raw[`F_CHG_REVERSE]   = chg_reverse_i;
  assign raw[`F_CHG_SHORT]     = chg_short_i;
  assign raw[`F_CHG_FAULT]     = |chg_fault_sense_i;
  assign raw[`F_CHG_CUR_LOW]   = chg_current_sense_i;
  assign raw[`F_CHG_DETECT]    = charger_detect_sense_i;
  assign raw[`F_A_SESSION]     = a_session_sense_i;
  assign raw[`F_B_SESSION]     = b_session_sense_i;
  assign raw[`F_ID_FLOAT]      = id_float_sense_i;
  assign raw[`F_ID_GROUND]     = id_ground_sense_i;
  assign raw[`F_ID_FACTORY]    = id_factory_sense_i;
  assign raw[`F_BUTTON1]       = button_i[0];
  assign raw[`F_BUTTON2]       = button_i[1];
  assign raw[`F_BUTTON3]       = button_i[2];
  assign raw[`F_THERM_HIGH]    = thermal_high_sense_i;
  assign raw[`F_THERM_LOW]     = thermal_low_sense_i;
  assign raw[`F_CLK_SRC]       = clk_src_sense_i;
  assign raw[`F_BATT_LOW_DET]  = batt_low_detect_sense_i;
  assign raw[`F_BATT_LOW_WARN] = batt_low_warn_sense_i;
  assign raw[`F_LP_BOOT]       = lowpower_boot_sense_i;
  assign raw[`C_CHG_ACTIVE]    = charger_active_sense_i;

  // Debounce then edge qualification per channel
  genvar g;
  generate
    for (g = 0; g < `N_CHAN; g = g + 1) begin : chan
      stable_filter u_filter (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .raw_i      (raw[g]),
        .rise_len_i (rise_len_of(g)),
        .fall_len_i (fall_len_of(g, button_debounce_ext)),
        .level_o    (settled[g])
      );
      edge_event u_edge (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .level_i   (settled[g]),
        .trig_i    (trig_of(g)),
        .pulse_o   (pulses[g])
      );
    end
  endgenerate

  assign bus_setup  = psel_i & penable_i & ~pready_o;
  assign bus_commit = psel_i & penable_i & pready_o & pwrite_i;

  // Register write strobes
  assign wr_status = write_hit(bus_commit, paddr_i, `ADDR_STATUS);
  assign wr_mask   = write_hit(bus_commit, paddr_i, `ADDR_MASK);
  assign wr_btn    = write_hit(bus_commit, paddr_i, `ADDR_BTN_CFG);

  // Flag, mask, setting and request next values
  always @* begin
    events = pulses[`N_FLAGS-1:0];
    events[`F_CHG_DETECT] = pulses[`F_CHG_DETECT] | pulses[`C_CHG_ACTIVE];
    clear_bits   = {`N_FLAGS{1'b0}};
    next_mask    = mask;
    next_btn_cfg = button_debounce_ext;
    if (wr_status) begin
      clear_bits = pwdata_i[`N_FLAGS-1:0];
    end
    if (wr_mask) begin
      next_mask = pwdata_i[`N_FLAGS-1:0];
    end
    if (wr_btn) begin
      next_btn_cfg = pwdata_i[`BTN_CFG_W-1:0];
    end
    next_status = (status & ~clear_bits) | events;
    next_irq    = |(next_status & ~next_mask);
  end

  // Read data and error for the access in progress
  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    case (paddr_i)
      `ADDR_STATUS:  next_rdata[`N_FLAGS-1:0] = status;
      `ADDR_MASK:    next_rdata[`N_FLAGS-1:0] = mask;
      `ADDR_SENSE:   next_rdata[24:0] = sense;
      `ADDR_BTN_CFG: next_rdata[`BTN_CFG_W-1:0] = button_debounce_ext;
      default:       next_err = 1'b1;
    endcase
  end

  // Event flags
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      status <= `STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Mask bits
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask <= `MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  // Button fall extension setting
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      button_debounce_ext <= `BTN_CFG_RESET;
    end else begin
      button_debounce_ext <= next_btn_cfg;
    end
  end

  // Interrupt request pin
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // Live sense snapshot, never written by software
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sense <= 25'h0000000;
    end else begin
      sense <= {seq_strap_sense_i, mode_strap_sense_i,
                lowpower_boot_sense_i, batt_low_warn_sense_i,
                batt_low_detect_sense_i, clk_src_sense_i,
                thermal_low_sense_i, thermal_high_sense_i,
                button_i, id_factory_sense_i, id_ground_sense_i,
                id_float_sense_i, b_session_sense_i, a_session_sense_i,
                charger_active_sense_i, charger_detect_sense_i,
                chg_current_sense_i, chg_fault_sense_i};
    end
  end

  // APB answer: one wait state, ready for one cycle
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= bus_setup;
    end
  end

  // Error response, only alongside ready
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pslverr_o <= 1'b0;
    end else if (bus_setup) begin
      pslverr_o <= next_err;
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // Read data, zero outside a read answer
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (bus_setup && !pwrite_i) begin
      prdata_o <= next_rdata;
    end else begin
      prdata_o <= 32'h00000000;
    end
  end
endmodule // pmic_interrupt_control

// ### pmic_irq_checker_assertions.sv
// Port-level assertions for the interrupt block
`timescale 1ns/100ps
module pmic_irq_checker (
  input wire        clk_i,
  input wire        sys_rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        conv_done_i,
  input wire        clk_src_sense_i,
  input wire [1:0]  mode_strap_sense_i,
  input wire [3:0]  seq_strap_sense_i,
  input wire        irq_o
);
  reg  [20:0] mask_m;
  wire        done_w = psel_i && penable_i && pready_o;
  // Shadow of the mask register
  always @(posedge clk_i) begin
    if (sys_rst_i)
      mask_m <= 21'h0FFFFF;
    else if (done_w && pwrite_i && paddr_i == 12'h004)
      mask_m <= pwdata_i[20:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_wait_ready; !pready_o ##1 pready_o; endsequence
  sequence s_conv_rise; !conv_done_i ##1 conv_done_i && !mask_m[0]; endsequence
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  chk_access_len: assert property (s_setup |=> s_wait_ready)
    else $error("access phase not two cycles");
  chk_err_addr: assert property (pready_o |-> pslverr_o == !(paddr_i == 12'h000 || paddr_i == 12'h004 ||
                                                            paddr_i == 12'h008 || paddr_i == 12'h00C))
    else $error("error response does not match address");
  chk_idle_rdata: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("read data not zero outside ready");
  chk_mask_read: assert property (done_w && !pwrite_i && paddr_i == 12'h004 |-> prdata_o[20:0] == mask_m)
    else $error("mask read back differs");
  chk_all_masked: assert property (mask_m == 21'h1FFFFF |-> !irq_o)
    else $error("request high with every mask set");
  chk_drop_cause: assert property ($fell(irq_o) |-> $past(done_w && pwrite_i && paddr_i[11:3] == 9'h000))
    else $error("request fell without status or mask write");
  chk_conv_irq: assert property (s_conv_rise |-> ##[1:5] irq_o)
    else $error("converter done gave no request");
  chk_clk_src: assert property ($changed(clk_src_sense_i) && !mask_m[17] |-> ##[1:5] irq_o)
    else $error("clock source change gave no request");
  chk_strap_read: assert property (done_w && !pwrite_i && paddr_i == 12'h008 |->
    prdata_o[24:19] == $past({seq_strap_sense_i, mode_strap_sense_i}, 2))
    else $error("strap sense differs");
endmodule // pmic_irq_checker

bind pmic_interrupt_control pmic_irq_checker u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .conv_done_i(conv_done_i), .clk_src_sense_i(clk_src_sense_i), .mode_strap_sense_i(mode_strap_sense_i),
  .seq_strap_sense_i(seq_strap_sense_i), .irq_o(irq_o)
);

// ### apb_host_model.sv
// Register bus host standing for the system processor
`timescale 1ns/100ps
module apb_host_model (
  input  wire        clk_i,
  input  wire        pready_i,
  input  wire        pslverr_i,
  input  wire [31:0] prdata_i,
  output reg         psel_o,
  output reg         penable_o,
  output reg         pwrite_o,
  output reg  [11:0] paddr_o,
  output reg  [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h00000000;
  end
  // Setup, then access held until ready
  task xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q, output e);
    begin
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      @(posedge clk_i);
      while (pready_i !== 1'b1) @(posedge clk_i);
      q = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
    end
  endtask
endmodule // apb_host_model

// ### pmic_interrupt_control_bench.sv
// Self-checking bench: register accesses and event scenarios
`timescale 1ns/100ps
module pmic_interrupt_control_bench;
  localparam [23:0] D   = 24'h000008;
  localparam [31:0] ALL = 32'h001FFFFF;
  reg         clk_i       = 1'b0;
  reg         sys_rst_i   = 1'b1;
  reg  [28:0] s           = 29'h0F000000;
  wire        psel_i;
  wire        penable_i;
  wire        pwrite_i;
  wire [11:0] paddr_i;
  wire [31:0] pwdata_i;
  wire [31:0] prdata_o;
  wire        pready_o;
  wire        pslverr_o;
  wire        irq_o;
  reg  [31:0] q;
  reg         e;
  integer     n_errors    = 0;
  integer     checks_done = 0;
  integer     cyc         = 0;
  integer     i;
  integer     f;
  integer     t;
  initial forever #25 clk_i = ~clk_i;
  pmic_interrupt_control #(
    .CHG_REV_CYC(D), .CHG_FAULT_CYC(D), .CHG_CUR_CYC(D), .CHG_DET_CYC(D), .CHG_ACT_CYC(D),
    .SESS_RISE_CYC(D), .SESS_FALL_CYC(D), .BUTTON_CYC(D), .THERM_CYC(D), .LP_BOOT_CYC(D)
  ) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .conv_done_i(s[0]), .conv2_done_i(s[1]), .chg_reverse_i(s[2]), .chg_short_i(s[3]),
    .chg_fault_sense_i(s[5:4]), .chg_current_sense_i(s[6]), .charger_detect_sense_i(s[7]),
    .charger_active_sense_i(s[8]), .a_session_sense_i(s[9]), .b_session_sense_i(s[10]),
    .id_float_sense_i(s[11]), .id_ground_sense_i(s[12]), .id_factory_sense_i(s[13]), .button_i(s[16:14]),
    .thermal_high_sense_i(s[17]), .thermal_low_sense_i(s[18]), .clk_src_sense_i(s[19]),
    .batt_low_detect_sense_i(s[20]), .batt_low_warn_sense_i(s[21]), .lowpower_boot_sense_i(s[22]),
    .mode_strap_sense_i(s[24:23]), .seq_strap_sense_i(s[28:25]), .irq_o(irq_o)
  );
  apb_host_model P (
    .clk_i(clk_i), .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o), .psel_o(psel_i),
    .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i)
  );
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      P.xfer(a, 1'b0, 32'h00000000, q, e);
      cmp(q, exp);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    P.xfer(a, 1'b1, d, q, e);
  endtask
  task ck_irq(input exp);
    begin
      @(negedge clk_i);
      cmp({31'h0, irq_o}, {31'h0, exp});
      @(posedge clk_i);
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
  initial begin
    w(12);
    sys_rst_i <= 1'b0;
    rd(12'h004, 32'h000FFFFF);
    rd(12'h000, 32'h00000000);
    rd(12'h010, 32'h00000000);
    cmp({31'h0, e}, 32'h00000001);
    rd(12'h008, {7'h0, s[28:4]});
    // Masked event latches without request
    s[0] <= 1'b1;
    w(6);
    ck_irq(1'b0);
    s[0] <= 1'b0;
    rd(12'h000, 32'h00000001);
    wr(12'h004, 32'h000FFFFE);
    ck_irq(1'b1);
    wr(12'h000, 32'h00000001);
    ck_irq(1'b0);
    rd(12'h000, 32'h00000000);
    // Three pending flags, clear two then the last one
    wr(12'h004, 32'h000DFFFC);
    s[0] <= 1'b1;
    s[1] <= 1'b1;
    s[19] <= 1'b1;
    w(6);
    rd(12'h000, 32'h00020003);
    wr(12'h000, 32'h00000003);
    ck_irq(1'b1);
    wr(12'h000, 32'h00020000);
    ck_irq(1'b0);
    // Event landing on the clearing write edge
    s[0] <= 1'b0;
    s[1] <= 1'b0;
    w(4);
    s[1] <= 1'b1;
    w(6);
    ck_irq(1'b1);
    fork
      wr(12'h000, 32'h00000003);
      begin
        w(2);
        s[0] <= 1'b1;
      end
    join
    ck_irq(1'b1);
    rd(12'h000, 32'h00000001);
    wr(12'h000, 32'h00000001);
    ck_irq(1'b0);
    // Short glitch filtered, long level flagged; current low flagged on its fall only
    for (i = 2; i < 4; i = i + 1) begin
      s[i] <= 1'b1;
      w(5);
      s[i] <= 1'b0;
      w(20);
      rd(12'h000, 32'h00000000);
      s[i] <= 1'b1;
      w(20);
      rd(12'h000, 32'h1 << i);
      s[i] <= 1'b0;
      wr(12'h000, ALL);
    end
    s[5:4] <= 2'h2;
    w(20);
    rd(12'h000, 32'h00000010);
    rd(12'h008, {7'h0, s[28:4]});
    wr(12'h008, 32'h00000000);
    rd(12'h008, {7'h0, s[28:4]});
    s[5:4] <= 2'h0;
    wr(12'h000, ALL);
    s[6] <= 1'b1;
    w(20);
    rd(12'h000, 32'h00000000);
    s[6] <= 1'b0;
    w(20);
    rd(12'h000, 32'h00000020);
    wr(12'h000, ALL);
    // Both edges of each level source
    for (i = 7; i < 23; i = i + 1) begin
      f = (i == 7) ? 6 : i - 2;
      t = (i > 10 && i < 14) ? 1850 : 650;
      s[i] <= !s[i];
      w(t);
      rd(12'h000, 32'h1 << f);
      wr(12'h000, ALL);
      s[i] <= !s[i];
      w(t);
      rd(12'h000, (i == 20) ? 32'h0 : 32'h1 << f);
      wr(12'h000, ALL);
    end
    // Button fall debounce stretched by its setting
    wr(12'h00C, 32'h00000003);
    rd(12'h00C, 32'h00000003);
    s[14] <= 1'b1;
    w(20);
    rd(12'h000, 32'h00001000);
    wr(12'h000, ALL);
    s[14] <= 1'b0;
    w(20);
    rd(12'h000, 32'h00000000);
    w(20);
    rd(12'h000, 32'h00001000);
    wr(12'h000, ALL);
    s[19] <= !s[19];
    w(6);
    ck_irq(1'b1);
    wr(12'h004, ALL);
    ck_irq(1'b0);
    rd(12'h000, 32'h00020000);
    summarize;
  end
endmodule // pmic_interrupt_control_bench
